// ===== logic/comparator_control_regs.v
// Control, conditioning and status logic around one analog voltage comparator
`timescale 1ns/1ps
`include "comparator_control_consts.vh"

module comparator_control_regs (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [4:0]  awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  output wire [1:0]  bresp,
  output wire        bvalid,
  input  wire        bready,
  input  wire [4:0]  araddr,
  input  wire        arvalid,
  output wire        arready,
  output wire [31:0] rdata,
  output wire [1:0]  rresp,
  output wire        rvalid,
  input  wire        rready,
  input  wire        sleep_standby,
  input  wire        sleep_powerdown,
  input  wire        compare_raw,
  input  wire        compare_ready,
  output wire        comparator_on,
  output wire [1:0]  power_profile,
  output wire [3:0]  hysteresis_level,
  output wire [2:0]  plus_pin_sel,
  output wire        minus_pin0_sel,
  output wire        minus_pin2_sel,
  output wire        minus_pin3_sel,
  output wire        minus_divider_sel,
  output wire [7:0]  divider_reference_code,
  output wire        out_pin_o,
  output wire        out_pin_oe,
  output wire        event_level,
  output wire        irq
);

  reg  [7:0]  comparator_control_reg;
  reg  [7:0]  input_select_reg;
  reg  [7:0]  divider_reference_code_reg;
  reg  [7:0]  interrupt_control_reg;
  reg         compare_irq_flag_reg;

  reg         level_sync1_reg;
  reg         level_sync2_reg;
  reg         live_compare_level_reg;

  reg         aw_have_reg;
  reg  [2:0]  aw_index_reg;
  reg         w_have_reg;
  reg  [7:0]  w_data_reg;
  reg         w_strb_reg;
  reg         bvalid_reg;
  reg         rvalid_reg;
  reg  [31:0] rdata_reg;

  wire        standby_run;
  wire        pin_output_enable;
  wire        enable_bit;
  wire        invert_bit;
  wire        startup_output_level;
  wire [2:0]  plus_input_sel;
  wire [2:0]  minus_input_sel;
  wire [1:0]  irq_edge_sel;
  wire        compare_irq_enable;

  wire        block_active;
  wire        clock_running;
  wire        conditioned_level;
  wire        rising_seen;
  wire        falling_seen;
  reg         edge_hit;

  wire        aw_take;
  wire        w_take;
  wire        write_fire;
  wire        ar_take;
  wire [2:0]  ar_index;
  wire        flag_clear;
  reg  [7:0]  read_value;

  assign standby_run          = comparator_control_reg[`BIT_STANDBY_RUN];
  assign pin_output_enable    = comparator_control_reg[`BIT_PIN_OUTPUT_ENABLE];
  assign enable_bit           = comparator_control_reg[`BIT_ENABLE];
  assign invert_bit           = input_select_reg[`BIT_INVERT];
  assign startup_output_level = input_select_reg[`BIT_STARTUP_LEVEL];
  assign plus_input_sel       = input_select_reg[`POS_PLUS_SEL_HI:`POS_PLUS_SEL_LO];
  assign minus_input_sel      = input_select_reg[`POS_MINUS_SEL_HI:`POS_MINUS_SEL_LO];
  assign irq_edge_sel         = interrupt_control_reg[`POS_EDGE_SEL_HI:`POS_EDGE_SEL_LO];
  assign compare_irq_enable   = interrupt_control_reg[`BIT_IRQ_ENABLE];

  // Comparator runs when enabled, except in power-down or halted standby
  assign block_active = enable_bit
                      & ~sleep_powerdown
                      & ~(sleep_standby & ~standby_run);

  // In standby the peripheral clock is stopped, so the synchroniser and flag setting hold; bus writes and flag clears still update
  assign clock_running = ~sleep_standby;

  assign comparator_on = block_active;
  assign power_profile = comparator_control_reg[`POS_POWER_PROFILE_HI:`POS_POWER_PROFILE_LO];

  // Hysteresis level decoded one-hot: bit0 none, bit1 small, bit2 medium, bit3 large
  assign hysteresis_level[0] = (comparator_control_reg[`POS_HYSTERESIS_HI:`POS_HYSTERESIS_LO]
                                == `HYS_NONE);
  assign hysteresis_level[1] = (comparator_control_reg[`POS_HYSTERESIS_HI:`POS_HYSTERESIS_LO]
                                == `HYS_SMALL);
  assign hysteresis_level[2] = (comparator_control_reg[`POS_HYSTERESIS_HI:`POS_HYSTERESIS_LO]
                                == `HYS_MEDIUM);
  assign hysteresis_level[3] = (comparator_control_reg[`POS_HYSTERESIS_HI:`POS_HYSTERESIS_LO]
                                == `HYS_LARGE);

  // Input multiplexer selects; reserved codes connect nothing
  assign plus_pin_sel[0]   = (plus_input_sel == `PLUS_PIN_0);
  assign plus_pin_sel[1]   = (plus_input_sel == `PLUS_PIN_3);
  assign plus_pin_sel[2]   = (plus_input_sel == `PLUS_PIN_4);
  assign minus_pin0_sel    = (minus_input_sel == `MINUS_PIN_0);
  assign minus_pin2_sel    = (minus_input_sel == `MINUS_PIN_2);
  assign minus_pin3_sel    = (minus_input_sel == `MINUS_PIN_3);
  assign minus_divider_sel = (minus_input_sel == `MINUS_DIVIDER_REF);

  assign divider_reference_code = divider_reference_code_reg;

  // Asynchronous path: start-up level until ready, then raw result xor invert
  assign conditioned_level = (block_active & compare_ready)
                           ? (compare_raw ^ invert_bit)
                           : startup_output_level;

  assign out_pin_o   = conditioned_level;
  assign out_pin_oe  = pin_output_enable & block_active;
  assign event_level = conditioned_level;

  // Synchroniser for the asynchronous level, third stage is the readable state
  always @(posedge aclk) begin
    if (!aresetn) begin
      level_sync1_reg        <= 1'b0;
      level_sync2_reg        <= 1'b0;
      live_compare_level_reg <= 1'b0;
    end else if (clock_running) begin
      level_sync1_reg        <= conditioned_level;
      level_sync2_reg        <= level_sync1_reg;
      live_compare_level_reg <= level_sync2_reg;
    end
  end

  // Synchronised value against its previous sample
  assign rising_seen  = level_sync2_reg & ~live_compare_level_reg;
  assign falling_seen = ~level_sync2_reg & live_compare_level_reg;

  always @* begin
    case (irq_edge_sel)
      `EDGE_ANY_CROSSING: edge_hit = rising_seen | falling_seen;
      `EDGE_FALLING:      edge_hit = falling_seen;
      `EDGE_RISING:       edge_hit = rising_seen;
      default:            edge_hit = 1'b0;
    endcase
  end

  // AXI4-Lite write channels are taken independently and held
  assign awready  = ~aw_have_reg & ~bvalid_reg;
  assign wready   = ~w_have_reg & ~bvalid_reg;
  assign aw_take  = awvalid & awready;
  assign w_take   = wvalid & wready;
  assign write_fire = aw_have_reg & w_have_reg & ~bvalid_reg;
  assign bvalid   = bvalid_reg;
  assign bresp    = `RESP_OKAY;

  assign flag_clear = write_fire & w_strb_reg
                    & (aw_index_reg == `IDX_COMPARATOR_STATUS)
                    & w_data_reg[`BIT_IRQ_FLAG];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg  <= 1'b0;
      aw_index_reg <= 3'h0;
      w_have_reg   <= 1'b0;
      w_data_reg   <= 8'h00;
      w_strb_reg   <= 1'b0;
      bvalid_reg   <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_have_reg  <= 1'b1;
        aw_index_reg <= awaddr[4:2];
      end
      if (w_take) begin
        w_have_reg <= 1'b1;
        w_data_reg <= wdata[7:0];
        w_strb_reg <= wstrb[0];
      end
      if (write_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Register writes; only byte lane 0 carries data
  always @(posedge aclk) begin
    if (!aresetn) begin
      comparator_control_reg     <= `RST_COMPARATOR_CONTROL;
      input_select_reg           <= `RST_INPUT_SELECT;
      divider_reference_code_reg <= `RST_DIVIDER_REFERENCE_CODE;
      interrupt_control_reg      <= `RST_INTERRUPT_CONTROL;
    end else if (write_fire && w_strb_reg) begin
      if (aw_index_reg == `IDX_COMPARATOR_CONTROL) begin
        comparator_control_reg <= w_data_reg & 8'hDF;
      end else if (aw_index_reg == `IDX_INPUT_SELECT) begin
        input_select_reg <= w_data_reg;
      end else if (aw_index_reg == `IDX_DIVIDER_REFERENCE_CODE) begin
        divider_reference_code_reg <= w_data_reg;
      end else if (aw_index_reg == `IDX_INTERRUPT_CONTROL) begin
        interrupt_control_reg <= w_data_reg & 8'h31;
      end
    end
  end

  // Flag: a new edge in the clearing cycle wins over the clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      compare_irq_flag_reg <= 1'b0;
    end else if (clock_running && edge_hit) begin
      compare_irq_flag_reg <= 1'b1;
    end else if (flag_clear) begin
      compare_irq_flag_reg <= 1'b0;
    end
  end

  assign irq = compare_irq_enable & compare_irq_flag_reg;

  // AXI4-Lite read: one outstanding, data registered
  assign arready  = ~rvalid_reg;
  assign ar_take  = arvalid & arready;
  assign ar_index = araddr[4:2];
  assign rvalid   = rvalid_reg;
  assign rdata    = rdata_reg;
  assign rresp    = `RESP_OKAY;

  always @* begin
    if (ar_index == `IDX_COMPARATOR_CONTROL) begin
      read_value = comparator_control_reg;
    end else if (ar_index == `IDX_INPUT_SELECT) begin
      read_value = input_select_reg;
    end else if (ar_index == `IDX_DIVIDER_REFERENCE_CODE) begin
      read_value = divider_reference_code_reg;
    end else if (ar_index == `IDX_INTERRUPT_CONTROL) begin
      read_value = interrupt_control_reg;
    end else if (ar_index == `IDX_COMPARATOR_STATUS) begin
      read_value = 8'h00;
      read_value[`BIT_LIVE_LEVEL] = live_compare_level_reg;
      read_value[`BIT_IRQ_FLAG]   = compare_irq_flag_reg;
    end else begin
      read_value = 8'h00;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {24'h000000, read_value};
    end else if (rvalid_reg && rready) begin
      rvalid_reg <= 1'b0;
    end
  end

endmodule // comparator_control_regs

// ===== logic/comparator_control_consts.vh
// Register map, field positions, reset values and encodings of the comparator control block
`ifndef COMPARATOR_CONTROL_CONSTS_VH
`define COMPARATOR_CONTROL_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_COMPARATOR_CONTROL     3'h0
`define IDX_INPUT_SELECT           3'h2
`define IDX_DIVIDER_REFERENCE_CODE 3'h5
`define IDX_INTERRUPT_CONTROL      3'h6
`define IDX_COMPARATOR_STATUS      3'h7

// Reset values
`define RST_COMPARATOR_CONTROL     8'h00
`define RST_INPUT_SELECT           8'h00
`define RST_DIVIDER_REFERENCE_CODE 8'hFF
`define RST_INTERRUPT_CONTROL      8'h00

// Control fields
`define BIT_STANDBY_RUN            7
`define BIT_PIN_OUTPUT_ENABLE      6
`define POS_POWER_PROFILE_HI       4
`define POS_POWER_PROFILE_LO       3
`define POS_HYSTERESIS_HI          2
`define POS_HYSTERESIS_LO          1
`define BIT_ENABLE                 0

// Input select fields
`define BIT_INVERT                 7
`define BIT_STARTUP_LEVEL          6
`define POS_PLUS_SEL_HI            5
`define POS_PLUS_SEL_LO            3
`define POS_MINUS_SEL_HI           2
`define POS_MINUS_SEL_LO           0

// Interrupt control fields
`define POS_EDGE_SEL_HI            5
`define POS_EDGE_SEL_LO            4
`define BIT_IRQ_ENABLE             0

// Status fields
`define BIT_LIVE_LEVEL             4
`define BIT_IRQ_FLAG               0

// Encodings
`define EDGE_ANY_CROSSING          2'h0
`define EDGE_FALLING               2'h2
`define EDGE_RISING                2'h3
`define PLUS_PIN_0                 3'h0
`define PLUS_PIN_3                 3'h3
`define PLUS_PIN_4                 3'h4
`define MINUS_PIN_0                3'h0
`define MINUS_PIN_2                3'h2
`define MINUS_PIN_3                3'h3
`define MINUS_DIVIDER_REF          3'h4
`define HYS_NONE                   2'h0
`define HYS_SMALL                  2'h1
`define HYS_MEDIUM                 2'h2
`define HYS_LARGE                  2'h3

// AXI responses
`define RESP_OKAY                  2'h0

`endif

// ===== sim/comparator_control_properties.sv
// Port-level assertions for the comparator control block
`timescale 1ns/1ps
module comparator_control_properties (
  input wire        aclk,
  input wire        aresetn,
  input wire        awvalid,
  input wire        awready,
  input wire        wvalid,
  input wire        wready,
  input wire [1:0]  bresp,
  input wire        bvalid,
  input wire        bready,
  input wire        arvalid,
  input wire        arready,
  input wire [31:0] rdata,
  input wire        rvalid,
  input wire        rready,
  input wire        sleep_standby,
  input wire        sleep_powerdown,
  input wire        comparator_on,
  input wire        out_pin_o,
  input wire        out_pin_oe,
  input wire        event_level,
  input wire        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_taken;
    arvalid && arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##2 bvalid && bresp == 2'h0)
    else $error("write not answered");
  a_read_answer: assert property (s_rd_taken |=> rvalid) else $error("read not answered");
  a_resp_hold: assert property (bvalid && !bready |=> bvalid) else $error("bvalid dropped");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data not held");
  a_read_upper: assert property (rvalid |-> !arready && rdata[31:8] == 24'h0)
    else $error("read upper bits set");
  a_event_level: assert property (event_level == out_pin_o)
    else $error("event level differs");
  a_pin_gate: assert property (out_pin_oe |-> comparator_on)
    else $error("pin driven while off");
  a_powerdown_off: assert property (sleep_powerdown |-> !comparator_on && !out_pin_oe)
    else $error("active in power-down");
  a_irq_sticky: assert property (irq |=> irq || $rose(bvalid))
    else $error("irq dropped without write");
  a_standby_freeze: assert property (sleep_standby && !irq |=> !irq || $rose(bvalid))
    else $error("irq rose in standby");
endmodule // comparator_control_properties

// ===== sim/comparator_core_model.sv
// Behavioural analog comparator with its input multiplexers
`timescale 1ns/1ps
module comparator_core_model (
  input  wire       aclk,
  input  wire       comparator_on,
  input  wire       slow,
  input  wire [7:0] vin,
  input  wire [2:0] plus_pin_sel,
  input  wire       minus_pin0_sel,
  input  wire       minus_pin2_sel,
  input  wire       minus_pin3_sel,
  input  wire       minus_divider_sel,
  input  wire [7:0] divider_reference_code,
  output reg        compare_raw,
  output wire       compare_ready
);
  // Voltages in units of the reference over 256; plus pin 0 is driven by the bench
  reg [7:0] vp;
  reg [7:0] vm;
  reg [4:0] cnt = 5'h00;
  always @* begin
    vp = plus_pin_sel[0] ? vin : plus_pin_sel[1] ? 8'h40 : plus_pin_sel[2] ? 8'hC0 : 8'h00;
    vm = minus_pin0_sel ? 8'h80 : minus_pin2_sel ? 8'h20 : minus_pin3_sel ? 8'hE0 : 8'hFF;
    if (minus_divider_sel) begin
      vm = divider_reference_code;
    end
    compare_raw = vp > vm;
  end
  // Start-up time counts from switch-on
  always @(posedge aclk) begin
    if (!comparator_on) begin
      cnt <= 5'h00;
    end else if (cnt != 5'h1F) begin
      cnt <= cnt + 5'h01;
    end
  end
  assign compare_ready = comparator_on && cnt >= (slow ? 5'h14 : 5'h02);
endmodule // comparator_core_model

// ===== sim/tb.sv
// Self-checking testbench of the comparator control block
`timescale 1ns/1ps
module tb;
  localparam [47:0] MUX_SEL = 48'h001A2324A48C;
  localparam [5:0]  MUX_EXP = 6'h15;
  reg         aclk = 1'b0;
  reg         aresetn, awvalid, wvalid, bready, arvalid, rready;
  reg         sleep_standby, sleep_powerdown, slow;
  reg  [4:0]  awaddr, araddr;
  reg  [31:0] wdata;
  reg  [7:0]  vin, d;
  wire        awready, wready, bvalid, arready, rvalid, compare_raw, compare_ready;
  wire        comparator_on, minus_pin0_sel, minus_pin2_sel, minus_pin3_sel, minus_divider_sel;
  wire        out_pin_o, out_pin_oe, event_level, irq;
  wire [1:0]  bresp, rresp, power_profile;
  wire [3:0]  hysteresis_level;
  wire [2:0]  plus_pin_sel;
  wire [7:0]  divider_reference_code;
  wire [31:0] rdata;
  integer     n_fail = 0;
  integer     cmp_count = 0;
  integer     k;
  always #2.5 aclk = ~aclk;
  comparator_control_regs comparator_control_regs_inst (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'h1),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .sleep_standby(sleep_standby),
    .sleep_powerdown(sleep_powerdown), .compare_raw(compare_raw),
    .compare_ready(compare_ready), .comparator_on(comparator_on),
    .power_profile(power_profile), .hysteresis_level(hysteresis_level),
    .plus_pin_sel(plus_pin_sel), .minus_pin0_sel(minus_pin0_sel),
    .minus_pin2_sel(minus_pin2_sel), .minus_pin3_sel(minus_pin3_sel),
    .minus_divider_sel(minus_divider_sel), .divider_reference_code(divider_reference_code),
    .out_pin_o(out_pin_o), .out_pin_oe(out_pin_oe), .event_level(event_level), .irq(irq));
  comparator_core_model comparator_core_model_inst (.aclk(aclk),
    .comparator_on(comparator_on), .slow(slow), .vin(vin), .plus_pin_sel(plus_pin_sel),
    .minus_pin0_sel(minus_pin0_sel), .minus_pin2_sel(minus_pin2_sel),
    .minus_pin3_sel(minus_pin3_sel), .minus_divider_sel(minus_divider_sel),
    .divider_reference_code(divider_reference_code), .compare_raw(compare_raw),
    .compare_ready(compare_ready));
  task final_report;
    begin
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge aclk);
  endtask
  task chk(input [127:0] nm, input [7:0] e, input [7:0] g);
    begin
      #1;
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // Ready and valid are sampled 1 ns after an edge, before the next one
  task wr(input [2:0] i, input [7:0] v);
    integer n;
    reg a, w, b;
    begin
      awaddr <= {i, 2'h0};
      wdata <= {24'h0, v};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b = 1'b0;
      for (n = 0; n < 50 && !b; n = n + 1) begin
        #1;
        a = awvalid & awready;
        w = wvalid & wready;
        b = bvalid;
        @(posedge aclk);
        if (a) awvalid <= 1'b0;
        if (w) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      if (!b) begin
        n_fail = n_fail + 1;
        final_report;
      end
    end
  endtask
  task rd(input [2:0] i, output [7:0] v);
    integer n;
    reg a, r;
    begin
      araddr <= {i, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      r = 1'b0;
      for (n = 0; n < 50 && !r; n = n + 1) begin
        #1;
        a = arvalid & arready;
        r = rvalid;
        v = rdata[7:0];
        @(posedge aclk);
        if (a) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      if (!r) begin
        n_fail = n_fail + 1;
        final_report;
      end
    end
  endtask
  task t_regs;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        rd(k[2:0], d);
        chk("reset value", (k == 5) ? 8'hFF : 8'h00, d);
      end
      wr(3'h0, 8'hFF);
      rd(3'h0, d);
      chk("control mask", 8'hDF, d);
      chk("read resp", 8'h00, rresp);
      for (k = 0; k < 4; k = k + 1) begin
        wr(3'h0, {3'h0, k[1:0], k[1:0], 1'b0});
        chk("profile", k[7:0], power_profile);
        chk("hysteresis", 8'h01 << k, hysteresis_level);
      end
      wr(3'h6, 8'hFF);
      rd(3'h6, d);
      chk("interrupt_control mask", 8'h31, d);
      wr(3'h6, 8'h00);
      wr(3'h1, 8'hFF);
      rd(3'h1, d);
      chk("reserved", 8'h00, d);
      wr(3'h5, 8'h80);
      chk("divider code", 8'h80, divider_reference_code);
      $display("test regs done");
    end
  endtask
  task t_startup;
    begin
      wr(3'h2, 8'h40);
      chk("startup high", 8'h01, out_pin_o);
      chk("off", 8'h00, comparator_on);
      slow <= 1'b1;
      wr(3'h0, 8'h01);
      chk("on", 8'h01, comparator_on);
      chk("startup hold", 8'h01, out_pin_o);
      cyc(25);
      chk("ready level", 8'h00, out_pin_o);
      $display("test startup done");
    end
  endtask
  task t_mux;
    begin
      slow <= 1'b0;
      for (k = 0; k < 6; k = k + 1) begin
        wr(3'h2, MUX_SEL[47 - 8 * k -: 8]);
        chk("pin level", MUX_EXP[5 - k], out_pin_o);
        cyc(4);
        rd(3'h7, d);
        chk("live level", MUX_EXP[5 - k], d[4]);
      end
      wr(3'h2, 8'h00);
      $display("test mux done");
    end
  endtask
  task t_edges;
    reg er, ef;
    begin
      for (k = 0; k < 4; k = k + 1) begin
        er = (k == 0 || k == 3);
        ef = (k == 0 || k == 2);
        wr(3'h6, {2'h0, k[1:0], 4'h1});
        wr(3'h7, 8'h01);
        vin <= 8'hA0;
        cyc(6);
        rd(3'h7, d);
        chk("flag rise", er, d[0]);
        chk("irq", er, irq);
        wr(3'h7, 8'h00);
        rd(3'h7, d);
        chk("flag kept", er, d[0]);
        wr(3'h6, {2'h0, k[1:0], 4'h0});
        chk("irq masked", 8'h00, irq);
        wr(3'h6, {2'h0, k[1:0], 4'h1});
        chk("irq held", er, irq);
        wr(3'h7, 8'h01);
        rd(3'h7, d);
        chk("flag clear", 8'h00, d[0]);
        vin <= 8'h60;
        cyc(6);
        rd(3'h7, d);
        chk("flag fall", ef, d[0]);
      end
      $display("test edges done");
    end
  endtask
  task t_sleep;
    begin
      wr(3'h0, 8'h41);
      chk("pin drive", 8'h01, out_pin_oe);
      wr(3'h0, 8'h01);
      chk("pin release", 8'h00, out_pin_oe);
      wr(3'h0, 8'h41);
      wr(3'h6, 8'h01);
      wr(3'h7, 8'h01);
      sleep_standby <= 1'b1;
      cyc(2);
      chk("standby halt", 8'h00, comparator_on);
      wr(3'h0, 8'hC1);
      chk("standby run", 8'h01, comparator_on);
      vin <= 8'hA0;
      cyc(6);
      chk("standby frozen", 8'h00, irq);
      sleep_standby <= 1'b0;
      cyc(6);
      chk("wake flag", 8'h01, irq);
      sleep_powerdown <= 1'b1;
      cyc(2);
      chk("powerdown", 8'h00, {out_pin_oe, comparator_on});
      sleep_powerdown <= 1'b0;
      $display("test sleep done");
    end
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {sleep_standby, sleep_powerdown, slow} = 3'h0;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0;
    vin = 8'h60;
    cyc(6);
    aresetn <= 1'b1;
    cyc(1);
    t_regs;
    t_startup;
    t_mux;
    t_edges;
    t_sleep;
    final_report;
  end
endmodule // tb
bind comparator_control_regs comparator_control_properties comparator_control_properties_inst (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .sleep_standby(sleep_standby), .sleep_powerdown(sleep_powerdown),
  .comparator_on(comparator_on), .out_pin_o(out_pin_o), .out_pin_oe(out_pin_oe),
  .event_level(event_level), .irq(irq));
